// ### common/msrp_map.svh
// Operation
// - Strobe pulse while deselected latches all records
// - Strobe at select start clears bit counter
// - 32 clocks per record, up to eight
// - Deselect abandons any transfer at once
// - Record sent low byte first, parity nibble top
// - Group advance command steps record group
// - Bytes msb first unless lsb-first bit set; command bytes are always shifted in msb first
// - Each writable bit has 7-bit address
// - Command byte: data bit then address
// - Config addresses 0 to 111 hit shadows
// - Last command bit clock strobes the write
// - Strobe low turns data driver off
// - Write lock takes effect when select idles
// - All pins high means port idle
// - Read data changes trailing edge, sampled leading edge; write data sampled trailing edge
// - Locked port runs only advance and test strobe
// - Burn enable also writes permanent element
`ifndef MSRP_MAP_SVH
`define MSRP_MAP_SVH
`define MSRP_REC_BITS 32
`define MSRP_NUM_REC 8
`define MSRP_GROUPS 4
`define MSRP_CFG_BITS 112
`define MSRP_CFG_LAST 7'h6F
`define MSRP_ADDR_LOCK 7'h00
`define MSRP_ADDR_LSBF 7'h01
`define MSRP_ADDR_TSG0 7'h70
`define MSRP_ADDR_TSG3 7'h73
`define MSRP_ADDR_RDIS 7'h7D
`define MSRP_ADDR_BURN 7'h7E
`define MSRP_ADDR_ADV 7'h7F
`define MSRP_CLK_MHZ 100
`define MSRP_LATCH_NS 500
`define MSRP_LATCH_CYC ((`MSRP_LATCH_NS * `MSRP_CLK_MHZ + 999) / 1000)
`define MSRP_OFF_CTRL 32'h0000_0000
`define MSRP_OFF_STAT 32'h0000_0004
`define MSRP_OFF_CFG0 32'h0000_0010
`define MSRP_OFF_REC0 32'h0000_0040
`endif

// ### common/msrp_pkg.sv
package msrp_pkg;
    typedef enum logic [1:0] {MSRP_IDLE, MSRP_READ, MSRP_WRITE} msrp_mode_e;
    typedef logic [31:0] msrp_word_t;
endpackage

// ### rtl/msrp_sync.sv
`timescale 1ns/1ps
module msrp_sync #(
    parameter int W = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } msrp_sync_s;
    msrp_sync_s st, next_st;
    always_comb begin
        next_st = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
    end
    // Pins idle high, so reset to ones avoids false edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end
    assign dout = st.s2;
endmodule

// ### rtl/msrp_axil.sv
`timescale 1ns/1ps
`include "msrp_map.svh"
module msrp_axil (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    typedef struct packed {
        logic aw_h;
        logic [7:0] aw;
        logic w_h;
        logic [31:0] w;
        logic bv;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
        logic we;
    } msrp_axil_s;
    msrp_axil_s st, next_st;
    always_comb begin
        next_st = st;
        next_st.we = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_h = 1'b1;
            next_st.aw = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_h = 1'b1;
            next_st.w = s_axi_wdata;
        end
        if (st.aw_h && st.w_h && !st.bv) begin
            next_st.we = s_axi_wstrb != 4'h0;
            next_st.bv = 1'b1;
            next_st.aw_h = 1'b0;
            next_st.w_h = 1'b0;
        end
        if (st.bv && s_axi_bready) begin
            next_st.bv = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rv = 1'b1;
            next_st.rd = rd_data;
            next_st.rr = rd_ok ? 2'h0 : 2'h2;
        end else if (st.rv && s_axi_rready) begin
            next_st.rv = 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign s_axi_awready = !st.aw_h && !st.bv;
    assign s_axi_wready = !st.w_h && !st.bv;
    assign s_axi_bresp = 2'h0;
    assign s_axi_bvalid = st.bv;
    assign s_axi_arready = !st.rv;
    assign s_axi_rdata = st.rd;
    assign s_axi_rresp = st.rr;
    assign s_axi_rvalid = st.rv;
    assign rd_addr = s_axi_araddr;
    assign wr_en = st.we;
    assign wr_addr = st.aw;
    assign wr_data = st.w;
endmodule

// ### rtl/msrp_port.sv
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "msrp_map.svh"
module msrp_port (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic port_select_low,
    input wire logic latch_direction_strobe,
    input wire logic serial_bit_clock_pin,
    input wire logic serial_data_pin_i,
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [`MSRP_CFG_BITS-1:0] config_bits,
    output logic [`MSRP_CFG_BITS-1:0] burn_pulse,
    output logic [3:0] test_strobe_command,
    output logic config_write_lock
);
    import msrp_pkg::*;
    localparam int NR = `MSRP_NUM_REC;
    localparam int NG = `MSRP_GROUPS;
    localparam int LCYC = `MSRP_LATCH_CYC;
    logic [3:0] pins;
    logic sel_n, strb, sck, sdi;
    logic wr_en;
    logic [7:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic rd_ok;
    // Records per group, loaded by software as the measured results
    msrp_word_t result_mem [NG*NR];
    msrp_word_t tx_latch [NR];
    typedef struct packed {
        msrp_mode_e mode;
        logic sck_d;
        logic strb_d;
        logic [7:0] bitcnt;
        logic [7:0] cmd;
        logic [$clog2(NG)-1:0] group;
        logic [7:0] lcnt;
        logic latch_go;
        logic lock_pend;
        logic lock;
        logic lsbf;
        logic rdis;
        logic burn;
        logic [`MSRP_CFG_BITS-1:0] shadow;
        logic [`MSRP_CFG_BITS-1:0] fuse;
        logic [`MSRP_CFG_BITS-1:0] bpulse;
        logic [3:0] tsg;
        logic dout;
        logic [15:0] nlatch;
    } msrp_port_s;
    msrp_port_s st, next_st;
    msrp_sync #(.W(4)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({port_select_low, latch_direction_strobe, serial_bit_clock_pin, serial_data_pin_i}),
        .dout(pins)
    );
    assign {sel_n, strb, sck, sdi} = pins;
    msrp_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );
    logic sck_rise, sck_fall;
    logic [2:0] rec_i, bit_i;
    logic [1:0] byte_i;
    logic [4:0] rbit;
    msrp_word_t cur_rec;
    assign sck_rise = sck && !st.sck_d;
    assign sck_fall = !sck && st.sck_d;
    assign rec_i = st.bitcnt[7:5];
    assign byte_i = st.bitcnt[4:3];
    assign bit_i = st.bitcnt[2:0];
    // Low byte first; within the byte the order follows the lsb-first bit
    assign rbit = {byte_i, st.lsbf ? bit_i : 3'(3'h7 - bit_i)};
    assign cur_rec = tx_latch[rec_i];
    always_comb begin
        next_st = st;
        next_st.sck_d = sck;
        next_st.strb_d = strb;
        next_st.latch_go = 1'b0;
        next_st.bpulse = '0;
        next_st.tsg = 4'h0;
        case (st.mode)
            MSRP_IDLE: begin
                // Deselected: time the strobe pulse that latches results
                if (strb && sel_n) begin
                    next_st.lcnt = (st.lcnt < 8'(LCYC)) ? 8'(st.lcnt + 8'h1) : st.lcnt;
                end else if (!strb) begin
                    next_st.lcnt = 8'h0;
                end
                if (!strb && st.strb_d && st.lcnt >= 8'(LCYC)) begin
                    next_st.latch_go = 1'b1;
                end
                if (!sel_n) begin
                    next_st.bitcnt = 8'h0;
                    next_st.mode = strb ? MSRP_READ : MSRP_WRITE;
                end
            end
            MSRP_READ: begin
                if (!strb) begin
                    next_st.bitcnt = 8'h0;
                end else if (sck_rise && st.bitcnt != 8'hFF) begin
                    // Bit zero stands from select; each release of the clock moves on
                    next_st.bitcnt = 8'(st.bitcnt + 8'h1);
                end
                if (strb) begin
                    next_st.dout = cur_rec[rbit];
                end
            end
            MSRP_WRITE: begin
                if (sck_rise) begin
                    next_st.cmd = {st.cmd[6:0], sdi};
                    next_st.bitcnt = 8'(st.bitcnt + 8'h1);
                    if (st.bitcnt[2:0] == 3'h7) begin
                        // Final bit's clock is the execute strobe
                        next_st = exec_cmd(next_st, {st.cmd[6:0], sdi});
                    end
                end
                if (strb) begin
                    next_st.mode = MSRP_READ;
                    next_st.bitcnt = 8'h0;
                end
            end
            default: next_st.mode = MSRP_IDLE;
        endcase
        if (sel_n) begin
            next_st.mode = MSRP_IDLE;
            if (st.lock_pend) begin
                next_st.lock = 1'b1;
            end
        end
        if (sel_n && strb && sck && sdi) begin
            next_st.bitcnt = 8'h0;
        end
        if (st.latch_go) begin
            next_st.nlatch = 16'(st.nlatch + 16'h1);
            next_st.group = '0;
        end
        if (wr_en && wr_addr == 8'(`MSRP_OFF_CTRL) && !st.lock) begin
            next_st.lsbf = wr_data[0];
            next_st.shadow[1] = wr_data[0];
        end
    end
    function automatic msrp_port_s exec_cmd(input msrp_port_s s, input logic [7:0] c);
        msrp_port_s r;
        logic [6:0] a;
        r = s;
        a = c[6:0];
        if (a == `MSRP_ADDR_ADV) begin
            r.group = r.group + 1'b1;
        end else if (a >= `MSRP_ADDR_TSG0 && a <= `MSRP_ADDR_TSG3) begin
            r.tsg[a[1:0]] = 1'b1;
        end else if (!s.lock && !s.lock_pend) begin
            if (a <= `MSRP_CFG_LAST) begin
                r.shadow[a] = c[7];
                if (s.burn && c[7]) begin
                    r.fuse[a] = 1'b1;
                    r.bpulse[a] = 1'b1;
                end
                if (a == `MSRP_ADDR_LSBF) begin
                    r.lsbf = c[7];
                end
                if (a == `MSRP_ADDR_LOCK && c[7]) begin
                    r.lock_pend = 1'b1;
                end
            end else if (a == `MSRP_ADDR_RDIS) begin
                r.rdis = c[7];
            end else if (a == `MSRP_ADDR_BURN) begin
                r.burn = c[7];
            end
        end
        return r;
    endfunction
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.mode <= MSRP_IDLE;
            st.sck_d <= 1'b1;
            st.strb_d <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
    always_ff @(posedge aclk) begin
        if (st.latch_go) begin
            for (int i = 0; i < NR; i++) begin
                tx_latch[i] <= result_mem[int'(st.group) * NR + i];
            end
        end
        if (wr_en && wr_addr >= 8'(`MSRP_OFF_REC0)) begin
            result_mem[wr_addr[6:2] - 5'h10] <= wr_data;
        end
    end
    logic [`MSRP_CFG_BITS-1:0] cfg_eff;
    logic [127:0] cfg_pad;
    assign cfg_eff = st.rdis ? st.shadow : (st.shadow | st.fuse);
    // Last config word is only partly filled; the rest reads as zero
    assign cfg_pad = {16'h0, cfg_eff};
    always_comb begin
        rd_ok = 1'b1;
        rd_data = 32'h0;
        if (rd_addr == 8'(`MSRP_OFF_CTRL)) begin
            rd_data = {31'h0, st.lsbf};
        end else if (rd_addr == 8'(`MSRP_OFF_STAT)) begin
            rd_data = {st.nlatch, 5'h0, st.bitcnt[7:5], st.lock, st.burn, st.rdis,
                2'(st.mode), 1'b0, st.group[1:0]};
        end else if (rd_addr >= 8'(`MSRP_OFF_CFG0) && rd_addr < 8'h20) begin
            rd_data = cfg_pad[32 * rd_addr[3:2] +: 32];
        end else if (rd_addr >= 8'(`MSRP_OFF_REC0) && rd_addr < 8'h80) begin
            rd_data = tx_latch[rd_addr[4:2]];
        end else begin
            rd_ok = 1'b0;
        end
    end
    assign serial_data_pin_o = st.dout;
    // Driver only while selected in read mode
    assign serial_data_pin_oe = (st.mode == MSRP_READ) && strb && !sel_n;
    assign config_bits = cfg_eff;
    assign burn_pulse = st.bpulse;
    assign test_strobe_command = st.tsg;
    assign config_write_lock = st.lock;
    property p_deselect_idle;
        @(posedge aclk) disable iff (!aresetn) sel_n |=> st.mode == MSRP_IDLE;
    endproperty
    a_deselect_idle: assert property (p_deselect_idle) else $error("Transfer not abandoned");
    property p_oe_off;
        @(posedge aclk) disable iff (!aresetn) !strb |-> !serial_data_pin_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("Driver on with strobe low");
    property p_cnt_clr;
        @(posedge aclk) disable iff (!aresetn)
        (st.mode == MSRP_READ && !strb) |=> st.bitcnt == 8'h0;
    endproperty
    a_cnt_clr: assert property (p_cnt_clr) else $error("Counter kept");
    property p_lock_hold;
        @(posedge aclk) disable iff (!aresetn) st.lock |=> $stable(st.shadow);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("Locked shadow changed");
    property p_lock_apply;
        @(posedge aclk) disable iff (!aresetn) (st.lock_pend && sel_n) |=> st.lock;
    endproperty
    a_lock_apply: assert property (p_lock_apply) else $error("Lock not applied");
    property p_burn_fuse;
        @(posedge aclk) disable iff (!aresetn) (|st.bpulse) |-> st.burn;
    endproperty
    a_burn_fuse: assert property (p_burn_fuse) else $error("Fuse written without burn");
    property p_latch_once;
        @(posedge aclk) disable iff (!aresetn) st.latch_go |=> !st.latch_go;
    endproperty
    a_latch_once: assert property (p_latch_once) else $error("Double latch");
    property p_count_step;
        @(posedge aclk) disable iff (!aresetn)
        (st.mode == MSRP_READ && strb && !sel_n && sck_rise && st.bitcnt < 8'hFE
         && !$past(sel_n)) |=> st.bitcnt == $past(st.bitcnt) + 8'h1;
    endproperty
    a_count_step: assert property (p_count_step) else $error("Bit counter did not step");
    // Eighth clock of an advance command while no latch is pending
    sequence s_adv_cmd;
        st.mode == MSRP_WRITE && !sel_n && sck_rise && st.bitcnt[2:0] == 3'h7
            && {st.cmd[5:0], sdi} == 7'h7F && !st.latch_go;
    endsequence
    property p_adv_step;
        @(posedge aclk) disable iff (!aresetn)
        s_adv_cmd |=> st.group == 2'($past(st.group) + 2'h1);
    endproperty
    a_adv_step: assert property (p_adv_step) else $error("Group did not advance");
endmodule

// ### verification/msrp_host.sv
`timescale 1ns/1ps
module msrp_host (
    output logic select_n,
    output logic strobe,
    output logic sclk,
    output logic hd,
    output logic hoe,
    input wire logic sdata
);
    localparam realtime HALF = 62.5;
    initial begin
        select_n = 1'b1;
        strobe = 1'b1;
        sclk = 1'b1;
        hd = 1'b1;
        hoe = 1'b0;
    end
    // Long high then a falling edge latches; the low runs on into the select
    task automatic latch_open();
        #700 strobe <= 1'b0;
        #100 select_n <= 1'b0;
        #100 strobe <= 1'b1;
        #100;
    endtask
    // Only the counter is cleared, so the latched data survive a reread
    task automatic reopen();
        #100 select_n <= 1'b0;
        #100 strobe <= 1'b0;
        #100 strobe <= 1'b1;
        #100;
    endtask
    task automatic shift(input int n, output logic [255:0] bits);
        bits = '0;
        for (int i = 0; i < n; i++) begin
            sclk <= 1'b0;
            #HALF bits[i] = sdata;
            sclk <= 1'b1;
            #HALF;
        end
    endtask
    task automatic w_open();
        strobe <= 1'b0;
        #100 select_n <= 1'b0;
        hoe <= 1'b1;
        #100;
    endtask
    task automatic w_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sclk <= 1'b0;
            hd <= b[i];
            #HALF sclk <= 1'b1;
            #HALF;
        end
    endtask
    task automatic close();
        #100 select_n <= 1'b1;
        #100 strobe <= 1'b1;
        hoe <= 1'b0;
        #100;
    endtask
endmodule

// ### verification/testbench.sv
`timescale 1ns/1ps
`include "msrp_map.svh"
module testbench;
    import msrp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic sel_n, stb, sclk, hd, hoe, sdata, so, oe, lock;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rd;
    logic [1:0] rs;
    logic [`MSRP_CFG_BITS-1:0] cfg, burn;
    logic [3:0] tsc;
    logic [255:0] bits;
    int fails = 0;
    int checks = 0;
    int ts_cnt [4];
    int burn_cnt;
    logic [7:0] row_cmd [4] = '{8'hAF, 8'hEF, 8'hC5, 8'h2F};
    int row_idx [4] = '{47, 111, 69, 47};
    logic row_exp [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    // Pull-up holds the data line high whenever nobody drives it
    assign sdata = oe ? so : (hoe ? hd : 1'b1);
    always #5 aclk = ~aclk;
    msrp_host msrp_host_inst (.select_n(sel_n), .strobe(stb), .sclk(sclk), .hd(hd),
        .hoe(hoe), .sdata(sdata));
    msrp_port msrp_port_inst (.aclk(aclk), .aresetn(aresetn), .port_select_low(sel_n),
        .latch_direction_strobe(stb), .serial_bit_clock_pin(sclk), .serial_data_pin_i(sdata),
        .serial_data_pin_o(so), .serial_data_pin_oe(oe), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .config_bits(cfg), .burn_pulse(burn),
        .test_strobe_command(tsc), .config_write_lock(lock));
    always @(posedge aclk) begin
        if (!aresetn) begin
            ts_cnt <= '{0, 0, 0, 0};
            burn_cnt <= 0;
        end else begin
            for (int i = 0; i < 4; i++) ts_cnt[i] <= ts_cnt[i] + int'(tsc[i]);
            burn_cnt <= burn_cnt + int'(burn[5]);
        end
    end
    task automatic complete_run();
        if (fails == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        bready <= 1'b0;
        check("bresp", bresp, 2'b00);
        if (n >= 100) check("write timeout", 1, 0);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (n >= 100) check("read timeout", 1, 0);
    endtask
    task automatic cmd(input logic [7:0] b);
        msrp_host_inst.w_open();
        msrp_host_inst.w_byte(b);
        msrp_host_inst.close();
    endtask
    function automatic logic [31:0] rec(input int r);
        logic [7:0] b;
        b = 8'(r);
        return {8'h50 | b, 8'h30 + b, 8'h0C + b, 8'h81 + b};
    endfunction
    // Serial order: low byte first, each byte msb first unless lsb-first
    function automatic logic [31:0] stream(input logic [31:0] v, input logic lsbf);
        logic [31:0] s;
        for (int i = 0; i < 32; i++) s[i] = lsbf ? v[i] : v[(i / 8) * 8 + 7 - i % 8];
        return s;
    endfunction
    task automatic read_all(input logic lsbf);
        msrp_host_inst.latch_open();
        check("oe read", oe, 1);
        msrp_host_inst.shift(256, bits);
        msrp_host_inst.close();
        for (int r = 0; r < 8; r++) check("record", bits[r*32 +: 32], stream(rec(r), lsbf));
    endtask
    initial begin
        #900000;
        check("run timeout", 1, 0);
        complete_run();
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        check("cfg reset", cfg, 0);
        check("lock reset", lock, 0);
        check("oe reset", oe, 0);
        axi_rd(8'(`MSRP_OFF_STAT));
        check("status reset", rd, 0);
        for (int r = 0; r < 8; r++) axi_wr(8'(`MSRP_OFF_REC0 + 4 * r), rec(r));
        read_all(1'b0);
        axi_rd(8'(`MSRP_OFF_REC0));
        check("latched rec0", rd, rec(0));
        axi_rd(8'hFC);
        check("unmapped resp", rs, 2'b10);
        for (int i = 0; i < 4; i++) begin
            cmd(row_cmd[i]);
            check("cfg bit", cfg[row_idx[i]], row_exp[i]);
        end
        cmd(8'h81);
        read_all(1'b1);
        cmd(8'h01);
        msrp_host_inst.latch_open();
        msrp_host_inst.shift(10, bits);
        msrp_host_inst.close();
        check("oe abort", oe, 0);
        msrp_host_inst.reopen();
        msrp_host_inst.shift(32, bits);
        msrp_host_inst.close();
        check("reread", bits[31:0], stream(rec(0), 1'b0));
        for (int i = 0; i < 4; i++) begin
            cmd(8'(8'hF0 + i));
            check("test strobe", ts_cnt[i], 1);
        end
        cmd(8'hFE);
        cmd(8'h85);
        check("burn pulse", burn_cnt, 1);
        cmd(8'h7E);
        cmd(8'h05);
        check("fuse kept", cfg[5], 1);
        cmd(8'hFD);
        check("shadow only", cfg[5], 0);
        cmd(8'h7D);
        cmd(8'hFF);
        axi_rd(8'(`MSRP_OFF_STAT));
        check("group", rd[1:0], 2'b01);
        msrp_host_inst.w_open();
        msrp_host_inst.w_byte(8'h80);
        #300;
        check("oe write", oe, 0);
        check("lock pending", lock, 0);
        msrp_host_inst.close();
        check("lock set", lock, 1);
        cmd(8'hAF);
        check("locked cfg", cfg[47], 0);
        cmd(8'hF0);
        check("locked strobe", ts_cnt[0], 2);
        complete_run();
    end
endmodule
